// ### rtl/fifo_core_pkg.sv
// constants, carrier types and state encodings shared by the buffer core
// assumes one clock for producer and consumer, reset active low and asynchronous
//
// Operation
// - reset returns read and write pointers to the first storage location
// - reset drives full and almost-full flags high, empty and almost-empty low
// - reset clears the output register and loads default flag offsets
// - a write cycle starts on the rising clock; data and enables sampled there
// - full and almost-full flags change only on rising write-clock edges
// - empty and almost-empty flags change only on rising read-clock edges
// - both ports run on the one clk; there are no separate read and write clocks
// - programmable-flag mode: with the load pin high, first write enable alone qualifies a write
// - unqualified write keeps the input register and stores nothing
// - written words go to consecutive locations, independent of reads
// - two-enable mode: both write enables must qualify a write
// - full flag low when full; high again after a valid read
// - writes are ignored while full; nothing is overwritten
// - both read enables low load the next word into the output register
// - either read enable high holds the output register
// - empty flag low when drained; high again after a valid write
// - reads are ignored while empty; pointer and output register hold
// - input and output words are nine bits wide
// - level on second enable/load pin during reset selects the mode; the core samples it on the first edge after reset
// - empty flag asserted whenever read pointer equals write pointer
// - default almost thresholds sit seven words from full and from empty
package fifo_core_pkg;
    localparam int DATA_W = 9;
    localparam int DEPTH_DEFAULT = 64;
    localparam int STAGE_DEPTH = 16;
    localparam int OFF_W = 16;
    localparam int OFF_BYTE_W = 8;
    localparam logic [OFF_W-1:0] OFF_DEFAULT = 16'h0007;

    // configuration picked up on the first edge after reset
    typedef enum logic [1:0] {
        CFG_RESET = 2'b00,
        CFG_PROG = 2'b01,
        CFG_WIDE = 2'b10
    } cfg_t;

    // offset register load order
    typedef enum logic [1:0] {
        LD_EMPTY_LO = 2'b00,
        LD_EMPTY_HI = 2'b01,
        LD_FULL_LO = 2'b10,
        LD_FULL_HI = 2'b11
    } load_step_t;

    typedef struct packed {
        logic full_flag_n;
        logic almost_full_flag_n;
        logic empty_flag_n;
        logic almost_empty_flag_n;
    } flags_t;

    localparam flags_t FLAGS_RESET = '{
        full_flag_n: 1'b1,
        almost_full_flag_n: 1'b1,
        empty_flag_n: 1'b0,
        almost_empty_flag_n: 1'b0
    };
endpackage

// ### rtl/word_ram.sv
// storage array with a registered read port that doubles as the output register
// assumes one clock; writer and reader never hit the same address in one cycle
`timescale 1ns/1ps
`default_nettype none
module word_ram #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 64,
    parameter int AW = 6
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [WIDTH-1:0] wrData,
    input wire logic rdEn,
    input wire logic [AW-1:0] rdAddr,
    output logic [WIDTH-1:0] rdData
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [WIDTH-1:0] rdData;
    } ram_state_t;

    ram_state_t st;
    ram_state_t next_st;

    // write and read both land on the same edge
    always_comb
    begin
        next_st = st;
        if (wrEn)
            next_st.mem[wrAddr] = wrData;
        if (rdEn)
            next_st.rdData = st.mem[rdAddr];
    end

    // read word stays put until the next accepted read
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            st <= '0;
        else if (ce)
            st <= next_st;
    end

    assign rdData = st.rdData;
endmodule // word_ram
`default_nettype wire

// ### rtl/stage_buffer.sv
// small valid/ready buffer between the write port and the storage array
// assumes one clock; the drain side may stall, then inReady falls
`timescale 1ns/1ps
`default_nettype none
module stage_buffer #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wrPtr;
        logic [AW-1:0] rdPtr;
        logic [CW-1:0] count;
    } stage_state_t;

    stage_state_t st;
    stage_state_t next_st;
    logic push;
    logic pop;

    // flags straight from the count, so full and empty never lie
    assign inReady = st.count != FULL_COUNT;
    assign outValid = st.count != '0;
    assign outData = st.mem[st.rdPtr];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    // ring pointers; depth must be a power of two
    always_comb
    begin
        next_st = st;
        if (push)
        begin
            next_st.mem[st.wrPtr] = inData;
            next_st.wrPtr = st.wrPtr + 1'b1;
        end
        if (pop)
            next_st.rdPtr = st.rdPtr + 1'b1;
        if (push && !pop)
            next_st.count = st.count + 1'b1;
        else if (pop && !push)
            next_st.count = st.count - 1'b1;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            st <= '0;
        else if (ce)
            st <= next_st;
    end
endmodule // stage_buffer
`default_nettype wire

// ### rtl/fifo_core.sv
// buffer core: write port, read port, fill flags and flag offset registers
// assumes producer and consumer run on clk; all inputs are clk-synchronous
`timescale 1ns/1ps
`default_nettype none
module fifo_core #(
    parameter int DEPTH = fifo_core_pkg::DEPTH_DEFAULT,
    parameter int STAGE = fifo_core_pkg::STAGE_DEPTH
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [fifo_core_pkg::DATA_W-1:0] wr_data,
    input wire logic wr_en_a_n,
    input wire logic wr_en_b_or_load,
    output logic wrReady,
    input wire logic rd_en_a_n,
    input wire logic rd_en_b_n,
    output logic [fifo_core_pkg::DATA_W-1:0] rd_data,
    output fifo_core_pkg::flags_t flags
);
    import fifo_core_pkg::*;

    localparam int AW = $clog2(DEPTH);
    localparam int PW = AW + 1;
    localparam logic [PW-1:0] DEPTH_WORDS = PW'(DEPTH);

    typedef struct packed {
        cfg_t cfg;
        load_step_t step;
        logic [PW-1:0] wrPtr;
        logic [PW-1:0] drainPtr;
        logic [PW-1:0] rdPtr;
        logic [PW-1:0] drainCopy;
        logic [PW-1:0] rdCopy;
        logic [OFF_W-1:0] emptyOff;
        logic [OFF_W-1:0] fullOff;
        flags_t flags;
    } core_state_t;

    localparam core_state_t CORE_RESET = '{
        cfg: CFG_RESET,
        step: LD_EMPTY_LO,
        wrPtr: '0,
        drainPtr: '0,
        rdPtr: '0,
        drainCopy: '0,
        rdCopy: '0,
        emptyOff: OFF_DEFAULT,
        fullOff: OFF_DEFAULT,
        flags: FLAGS_RESET
    };

    core_state_t st;
    core_state_t next_st;
    logic writeQual;
    logic offsetLoad;
    logic wrAccept;
    logic rdAccept;
    logic stageValid;
    logic stageReady;
    logic stageOutValid;
    logic stageOutReady;
    logic [DATA_W-1:0] stageOutData;
    logic drain;
    logic [PW-1:0] fillWords;
    logic [PW-1:0] readWords;

    // words between two free-running pointers; wrap is absorbed by the extra bit
    function automatic logic [PW-1:0] words(input logic [PW-1:0] ahead,
                                            input logic [PW-1:0] behind);
        words = ahead - behind;
    endfunction

    // ------------------------------------------------------------------
    // write and read qualification
    // ------------------------------------------------------------------
    // data and enables are all sampled on the same rising edge
    // in either mode a store needs enable one low and the second pin high
    always_comb
    begin
        writeQual = (st.cfg != CFG_RESET) && !wr_en_a_n && wr_en_b_or_load;
        offsetLoad = (st.cfg == CFG_PROG) && !wr_en_a_n && !wr_en_b_or_load;
        stageValid = writeQual && st.flags.full_flag_n;
        wrAccept = stageValid && stageReady;
        rdAccept = (st.cfg != CFG_RESET) && !rd_en_a_n && !rd_en_b_n
            && st.flags.empty_flag_n;
        // reads win the array port; staged words wait a cycle
        stageOutReady = !rdAccept;
        drain = stageOutValid && stageOutReady;
    end

    assign wrReady = stageReady && st.flags.full_flag_n;

    // ------------------------------------------------------------------
    // staging buffer and storage array
    // ------------------------------------------------------------------
    stage_buffer #(
        .WIDTH(DATA_W),
        .DEPTH(STAGE)
    ) u_stage (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .inValid(stageValid),
        .inReady(stageReady),
        .inData(wr_data),
        .outValid(stageOutValid),
        .outReady(stageOutReady),
        .outData(stageOutData)
    );

    // read port register is the output register, cleared by reset
    word_ram #(
        .WIDTH(DATA_W),
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_ram (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .wrEn(drain),
        .wrAddr(st.drainPtr[AW-1:0]),
        .wrData(stageOutData),
        .rdEn(rdAccept),
        .rdAddr(st.rdPtr[AW-1:0]),
        .rdData(rd_data)
    );

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    // pointers, mode pick-up, offset loading and flags from next values
    always_comb
    begin
        next_st = st;
        unique case (st.cfg)
            CFG_RESET:
                next_st.cfg = wr_en_b_or_load ? CFG_WIDE : CFG_PROG;
            CFG_PROG, CFG_WIDE:
                next_st.cfg = st.cfg;
            default:
                next_st.cfg = CFG_RESET;
        endcase
        if (offsetLoad)
        begin
            unique case (st.step)
                LD_EMPTY_LO:
                begin
                    next_st.emptyOff[OFF_BYTE_W-1:0] = wr_data[OFF_BYTE_W-1:0];
                    next_st.step = LD_EMPTY_HI;
                end
                LD_EMPTY_HI:
                begin
                    next_st.emptyOff[OFF_W-1:OFF_BYTE_W] = wr_data[OFF_BYTE_W-1:0];
                    next_st.step = LD_FULL_LO;
                end
                LD_FULL_LO:
                begin
                    next_st.fullOff[OFF_BYTE_W-1:0] = wr_data[OFF_BYTE_W-1:0];
                    next_st.step = LD_FULL_HI;
                end
                LD_FULL_HI:
                begin
                    next_st.fullOff[OFF_W-1:OFF_BYTE_W] = wr_data[OFF_BYTE_W-1:0];
                    next_st.step = LD_EMPTY_LO;
                end
            endcase
        end
        if (wrAccept)
            next_st.wrPtr = st.wrPtr + 1'b1;
        if (drain)
            next_st.drainPtr = st.drainPtr + 1'b1;
        if (rdAccept)
            next_st.rdPtr = st.rdPtr + 1'b1;
        // registered copies; a lagging copy only makes a flag pessimistic
        next_st.drainCopy = st.drainPtr;
        next_st.rdCopy = st.rdPtr;
        fillWords = words(next_st.wrPtr, next_st.rdCopy);
        readWords = words(next_st.drainCopy, next_st.rdPtr);
        // full side counts staged words too, so the array never overruns
        next_st.flags.full_flag_n = fillWords != DEPTH_WORDS;
        next_st.flags.almost_full_flag_n =
            (int'(fillWords) + int'(next_st.fullOff)) < DEPTH;
        next_st.flags.empty_flag_n = readWords != '0;
        next_st.flags.almost_empty_flag_n =
            int'(readWords) > int'(next_st.emptyOff);
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    // reset puts pointers at location zero and flags at their idle levels
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            st <= CORE_RESET;
        else if (ce)
            st <= next_st;
    end

    assign flags = st.flags;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sequence fullRead_s;
        !st.flags.full_flag_n && ce && rdAccept;
    endsequence

    sequence emptyWrite_s;
        !st.flags.empty_flag_n && ce && wrAccept && !stageOutValid;
    endsequence

    reset_pointers_a: assert property (
        st.cfg == CFG_RESET |-> (st.wrPtr == '0) && (st.rdPtr == '0) && (st.drainPtr == '0))
        else $error("pointers not at first location after reset");

    reset_flags_a: assert property (
        st.cfg == CFG_RESET |-> flags == FLAGS_RESET)
        else $error("flags not at reset levels");

    reset_output_a: assert property (
        st.cfg == CFG_RESET |-> (rd_data == '0) && (st.emptyOff == OFF_DEFAULT)
            && (st.fullOff == OFF_DEFAULT))
        else $error("output register or offsets not at defaults");

    mode_pick_a: assert property (
        st.cfg == CFG_RESET && ce |=>
            st.cfg == ($past(wr_en_b_or_load) ? CFG_WIDE : CFG_PROG))
        else $error("mode not taken from second enable pin");

    write_advance_a: assert property (
        ce && wrAccept |=> st.wrPtr == $past(st.wrPtr) + PW'(1))
        else $error("accepted write did not advance write pointer");

    write_hold_a: assert property (
        ce && wr_en_a_n |=> $stable(st.wrPtr))
        else $error("write pointer moved without enable");

    wide_qual_a: assert property (
        ce && st.cfg == CFG_WIDE && !wr_en_b_or_load |=> $stable(st.wrPtr))
        else $error("two-enable mode stored with second enable low");

    full_block_a: assert property (
        ce && !st.flags.full_flag_n |=> $stable(st.wrPtr))
        else $error("write stored while full");

    full_release_a: assert property (
        fullRead_s ##1 ce |=> st.flags.full_flag_n)
        else $error("full flag not released two edges after read");

    empty_release_a: assert property (
        emptyWrite_s ##1 (ce && !rdAccept) ##1 ce |=> st.flags.empty_flag_n)
        else $error("empty flag not released three edges after write");

    read_load_a: assert property (
        ce && rdAccept |=> st.rdPtr == $past(st.rdPtr) + PW'(1))
        else $error("accepted read did not advance read pointer");

    read_hold_a: assert property (
        ce && (rd_en_a_n || rd_en_b_n) |=> $stable(rd_data) && $stable(st.rdPtr))
        else $error("output register changed without both read enables");

    empty_block_a: assert property (
        ce && !st.flags.empty_flag_n |=> $stable(rd_data) && $stable(st.rdPtr))
        else $error("read taken while empty");

    empty_equal_a: assert property (
        st.flags.empty_flag_n == (st.drainCopy != st.rdPtr))
        else $error("empty flag disagrees with pointers");

    default_afull_a: assert property (
        st.cfg != CFG_RESET && st.fullOff == OFF_DEFAULT
            && words(st.wrPtr, st.rdCopy) == DEPTH_WORDS - PW'(OFF_DEFAULT)
            |-> !st.flags.almost_full_flag_n)
        else $error("almost-full not low at default threshold");

    // ------------------------------------------------------------------
    // occupancy, write qualification, offsets, mode and clock enable
    // ------------------------------------------------------------------
    // a broken bound means one pointer ran past another and words were lost
    fill_bound_a: assert property (
        words(st.wrPtr, st.rdCopy) <= DEPTH_WORDS)
        else $error("more words taken than the store holds");

    drain_bound_a: assert property (
        words(st.drainPtr, st.rdPtr) <= DEPTH_WORDS)
        else $error("array overrun by drained words");

    read_bound_a: assert property (
        words(st.drainCopy, st.rdPtr) <= DEPTH_WORDS)
        else $error("read pointer passed the stored words");

    full_count_a: assert property (
        words(st.wrPtr, st.rdCopy) == DEPTH_WORDS |-> !st.flags.full_flag_n)
        else $error("full flag high with the store full");

    default_aempty_a: assert property (
        st.emptyOff == OFF_DEFAULT
            && words(st.drainCopy, st.rdPtr) == PW'(OFF_DEFAULT)
            |-> !st.flags.almost_empty_flag_n)
        else $error("almost-empty not low at default threshold");

    // load pin high leaves enable one as the only write qualifier
    prog_write_a: assert property (
        ce && st.cfg == CFG_PROG && !wr_en_a_n && wr_en_b_or_load && wrReady
            |=> st.wrPtr == $past(st.wrPtr) + PW'(1))
        else $error("programmable-mode write not stored");

    wide_write_a: assert property (
        ce && st.cfg == CFG_WIDE && !wr_en_a_n && wr_en_b_or_load && wrReady
            |=> st.wrPtr == $past(st.wrPtr) + PW'(1))
        else $error("two-enable write not stored");

    ready_full_a: assert property (
        !st.flags.full_flag_n |-> !wrReady)
        else $error("ready shown while full");

    load_no_store_a: assert property (
        ce && offsetLoad |=> $stable(st.wrPtr))
        else $error("offset load stored a word");

    // each load moves the byte sequence on; nothing else touches offsets
    offset_step_a: assert property (
        ce && offsetLoad |=> st.step != $past(st.step))
        else $error("offset load did not advance the sequence");

    offset_hold_a: assert property (
        ce && !offsetLoad |=> $stable(st.emptyOff) && $stable(st.fullOff))
        else $error("offsets changed without a load");

    mode_hold_a: assert property (
        ce && st.cfg != CFG_RESET |=> st.cfg == $past(st.cfg))
        else $error("mode changed outside reset");

    // low enable freezes everything, flags included
    ce_freeze_a: assert property (
        !ce |=> $stable(st))
        else $error("state moved while clock enable was low");
endmodule // fifo_core
`default_nettype wire

// ### tb/stream_partner.sv
// producer and consumer model for the buffer core's write and read ports
// assumes the bench calls its tasks from one process, 1 ns after a rising clk
`timescale 1ns/1ps
`default_nettype none
module stream_partner (
    input wire logic clk,
    input wire logic wrReady,
    input wire logic [fifo_core_pkg::DATA_W-1:0] rd_data,
    input wire fifo_core_pkg::flags_t flags,
    output logic [fifo_core_pkg::DATA_W-1:0] wr_data,
    output logic wr_en_a_n,
    output logic wr_en_b_or_load,
    output logic rd_en_a_n,
    output logic rd_en_b_n
);
    import fifo_core_pkg::*;
    logic modeLevel;
    // idle levels; the load pin is set by set_mode
    initial
    begin
        wr_data = 9'h000;
        wr_en_a_n = 1'b1;
        rd_en_a_n = 1'b1;
        rd_en_b_n = 1'b1;
    end
    // the mode level must already sit on the pin while reset is low
    task automatic set_mode(input logic level);
        modeLevel = level;
        wr_en_b_or_load = level;
    endtask
    // released data lines show the inverse, so a stale word cannot pass
    task automatic wr_idle();
        wr_en_a_n = 1'b1;
        wr_en_b_or_load = modeLevel;
        wr_data = ~wr_data;
    endtask
    // word held until an edge sees ready, or the wait runs out
    task automatic push(input logic [DATA_W-1:0] word, input int waitMax, output logic ok);
        ok = 1'b0;
        wr_data = word;
        wr_en_a_n = 1'b0;
        wr_en_b_or_load = 1'b1;
        for (int n = 0; n < waitMax && !ok; n++)
        begin
            @(negedge clk);
            ok = (wrReady === 1'b1);
            @(posedge clk);
        end
        #1;
    endtask
    // raw enables for one edge, then released
    task automatic drive_wr(input logic a, input logic b, input logic [DATA_W-1:0] word);
        wr_data = word;
        wr_en_a_n = a;
        wr_en_b_or_load = b;
        @(posedge clk);
        #1;
        wr_idle();
    endtask
    task automatic try_read(input logic a, input logic b);
        rd_en_a_n = a;
        rd_en_b_n = b;
        @(posedge clk);
        #1;
        rd_en_a_n = 1'b1;
        rd_en_b_n = 1'b1;
    endtask
    task automatic rd_idle();
        rd_en_a_n = 1'b1;
        rd_en_b_n = 1'b1;
    endtask
    // gap 0 keeps the enables low for back-to-back reads; a gap stalls
    task automatic pop(input int gap, output logic [DATA_W-1:0] word, output logic ok);
        if (gap > 0 || flags.empty_flag_n !== 1'b1)
            rd_idle();
        repeat (gap) @(posedge clk);
        if (gap > 0)
            #1;
        for (int n = 0; n < 40 && flags.empty_flag_n !== 1'b1; n++)
        begin
            @(posedge clk);
            #1;
        end
        ok = (flags.empty_flag_n === 1'b1);
        word = rd_data;
        if (ok)
        begin
            rd_en_a_n = 1'b0;
            rd_en_b_n = 1'b0;
            @(posedge clk);
            #1;
            word = rd_data;
        end
    endtask
endmodule // stream_partner
`default_nettype wire

// ### tb/testbench.sv
// self-checking bench for the buffer core with a 16-word store
// assumes the package and design files are compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import fifo_core_pkg::*;
    localparam int DEPTH = 16;
    logic clk, resetn, ce, wrReady, wr_en_a_n, wr_en_b_or_load, rd_en_a_n, rd_en_b_n, ok;
    logic [DATA_W-1:0] wr_data, rd_data, w;
    flags_t flags;
    int fails, checked;

    fifo_core #(.DEPTH(DEPTH)) uut (.clk(clk), .resetn(resetn), .ce(ce), .wr_data(wr_data),
        .wr_en_a_n(wr_en_a_n), .wr_en_b_or_load(wr_en_b_or_load), .wrReady(wrReady),
        .rd_en_a_n(rd_en_a_n), .rd_en_b_n(rd_en_b_n), .rd_data(rd_data), .flags(flags));
    stream_partner pm (.clk(clk), .wrReady(wrReady), .rd_data(rd_data), .flags(flags),
        .wr_data(wr_data), .wr_en_a_n(wr_en_a_n), .wr_en_b_or_load(wr_en_b_or_load),
        .rd_en_a_n(rd_en_a_n), .rd_en_b_n(rd_en_b_n));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ----------------------------------------
    // compare and helper tasks
    // ----------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check_bit(input logic got, input logic exp, input string what);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask
    task automatic check_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp,
        input string what);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic check_flags(input flags_t got, input flags_t exp);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR at %0t: flags got %b expected %b", $time, got, exp);
        end
    endtask
    function automatic logic [DATA_W-1:0] fw(input int i);
        return DATA_W'(i) * 9'h025 + 9'h100;
    endfunction
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // a hung handshake ends the run through the closing report
    task automatic put(input logic [DATA_W-1:0] word);
        pm.push(word, 8, ok);
        pm.wr_idle();
        check_bit(ok, 1'b1, "write taken");
        if (!ok)
            finish_test();
        idle(1);
    endtask
    task automatic pop_check(input int gap, input logic [DATA_W-1:0] exp);
        pm.pop(gap, w, ok);
        check_bit(ok, 1'b1, "read possible");
        if (!ok)
            finish_test();
        check_word(w, exp, "read word");
    endtask
    // reset held 20 cycles; outputs checked while it is still low
    task automatic do_reset(input logic mode);
        pm.set_mode(mode);
        resetn = 1'b0;
        idle(20);
        check_flags(flags, FLAGS_RESET);
        check_word(rd_data, 9'h000, "reset output");
        check_bit(wrReady, 1'b1, "reset ready");
        resetn = 1'b1;
        idle(2);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic test_qualify();
        pm.drive_wr(1'b0, 1'b0, 9'h055);
        idle(1);
        pm.drive_wr(1'b1, 1'b1, 9'h0AA);
        idle(6);
        check_bit(flags.empty_flag_n, 1'b0, "no store");
        put(9'h155);
        ce = 1'b0;
        idle(6);
        check_bit(flags.empty_flag_n, 1'b0, "frozen");
        ce = 1'b1;
        idle(6);
        pm.try_read(1'b0, 1'b1);
        idle(1);
        pm.try_read(1'b1, 1'b0);
        check_word(rd_data, 9'h000, "held output");
        pop_check(0, 9'h155);
        pm.rd_idle();
        idle(6);
        check_bit(flags.empty_flag_n, 1'b0, "drained");
        pm.try_read(1'b0, 1'b0);
        check_word(rd_data, 9'h155, "read while empty");
        $display("test qualify done");
    endtask
    task automatic test_fill();
        for (int i = 1; i <= DEPTH; i++)
        begin
            put(fw(i));
            idle(6);
            check_bit(flags.almost_empty_flag_n, i > 7, "almost empty");
            check_bit(flags.almost_full_flag_n, i + 7 < DEPTH, "almost full");
            check_bit(flags.full_flag_n, i != DEPTH, "full");
        end
        pm.push(9'h1EE, 3, ok);
        pm.wr_idle();
        check_bit(ok, 1'b0, "write while full");
        pop_check(0, fw(1));
        pm.rd_idle();
        idle(4);
        check_bit(flags.full_flag_n, 1'b1, "full released");
        put(fw(DEPTH + 1));
        idle(6);
        for (int i = 2; i <= DEPTH + 1; i++)
            pop_check((i % 3 == 0) ? 2 : 0, fw(i));
        pm.rd_idle();
        idle(6);
        check_bit(flags.empty_flag_n, 1'b0, "empty again");
        $display("test fill done");
    endtask
    task automatic test_prog();
        do_reset(1'b0);
        pm.drive_wr(1'b0, 1'b0, 9'h002);
        idle(1);
        pm.drive_wr(1'b0, 1'b0, 9'h000);
        idle(1);
        pm.drive_wr(1'b0, 1'b0, 9'h00D);
        idle(1);
        pm.drive_wr(1'b0, 1'b0, 9'h000);
        idle(1);
        for (int i = 1; i <= 3; i++)
        begin
            put(fw(i));
            idle(6);
            check_bit(flags.almost_empty_flag_n, i > 2, "programmed offset");
            check_bit(flags.almost_full_flag_n, i + 13 < DEPTH, "full offset");
        end
        for (int i = 1; i <= 3; i++)
            pop_check(0, fw(i));
        pm.rd_idle();
        $display("test prog done");
    endtask
    task automatic test_midrun_reset();
        do_reset(1'b1);
        for (int i = 1; i <= 4; i++)
            put(fw(i + 40));
        idle(6);
        pop_check(0, fw(41));
        pm.rd_idle();
        do_reset(1'b1);
        idle(6);
        check_bit(flags.empty_flag_n, 1'b0, "pointers cleared");
        put(9'h0C3);
        pop_check(0, 9'h0C3);
        pm.rd_idle();
        $display("test midrun reset done");
    endtask

    initial
    begin
        repeat (30000) @(posedge clk);
        fails++;
        $display("ERROR at %0t: run timed out", $time);
        finish_test();
    end
    initial
    begin
        fails = 0;
        checked = 0;
        ce = 1'b1;
        do_reset(1'b1);
        $display("test reset done");
        test_qualify();
        test_fill();
        test_prog();
        test_midrun_reset();
        finish_test();
    end
endmodule // testbench
`default_nettype wire
